/* hdl/lmc_pkg.sv */
package lmc_pkg;
   // clock and timing
   localparam int CLK_KHZ       = 40000;       // 40 MHz system clock
   localparam int HOLD_MS       = 1000;        // button hold before a change acts
   localparam int HOLD_CYC      = HOLD_MS * CLK_KHZ;
   localparam int MSG_MS        = 1000;        // time a message stays up
   localparam int MSG_CYC       = MSG_MS * CLK_KHZ;
   localparam int TMR_W         = 26;
   localparam int DIV_CYC       = 32;          // divider iterations

   // values in units of 0.01 pF or 0.01 %
   localparam int VAL_W         = 20;
   localparam logic [19:0] MIN_SPAN     = 20'h0014A;  // 3.30 pF
   localparam logic [19:0] LRP_RST      = 20'h00000;  // 0 pF
   localparam logic [19:0] URP_RST      = 20'h50910;  // 3300 pF
   localparam logic [19:0] VAL_MAX      = 20'hFFFFF;
   localparam logic [31:0] PCT_SCALE    = 32'h00002710; // 100.00 %

   // step size as decade exponent: 0.01 * 10^exp, 0.01 .. 1000
   localparam logic [2:0]  STEP_RST     = 3'h2;       // 1.00
   localparam logic [2:0]  STEP_MAX     = 3'h5;
   localparam logic [1:0]  LOCK_RST     = 2'h0;
   localparam logic [1:0]  LOCK_MAX     = 2'h3;

   // menu items {level, rotary}
   localparam logic [4:0]  ITEM_LVL0    = 5'h00;
   localparam logic [4:0]  ITEM_REP     = 5'h01;
   localparam logic [4:0]  ITEM_STEP    = 5'h09;
   localparam logic [4:0]  ITEM_LRP     = 5'h0E;
   localparam logic [4:0]  ITEM_URP     = 5'h0F;
   localparam logic [4:0]  ITEM_LVL1    = 5'h10;
   localparam logic [4:0]  ITEM_FAC     = 5'h12;
   localparam logic [4:0]  ITEM_LOCK    = 5'h1F;

   // register byte offsets
   localparam logic [7:0]  REG_STATUS   = 8'h00;
   localparam logic [7:0]  REG_LRP      = 8'h04;
   localparam logic [7:0]  REG_URP      = 8'h08;
   localparam logic [7:0]  REG_STEP     = 8'h0C;
   localparam logic [7:0]  REG_LOCK     = 8'h10;
   localparam logic [7:0]  REG_PCT      = 8'h14;
   localparam logic [7:0]  REG_DISP     = 8'h18;

   typedef enum logic [3:0] {
      MSG_PRIM    = 4'h0,  // primary_value in pF
      MSG_PCT     = 4'h1,  // primary_value in percent
      MSG_REP     = 4'h2,  // representation selection
      MSG_STEP    = 4'h3,  // step size prompt
      MSG_LRP     = 4'h4,  // lower_range_point
      MSG_URP     = 4'h5,  // upper_range_point
      MSG_LOCK    = 4'h6,  // lock_level_prompt
      MSG_LVL_CHG = 4'h7,  // level change message
      MSG_LVL_SEL = 4'h8,  // level select message
      MSG_CONFIRM = 4'h9,  // confirm_msg
      MSG_FACTORY = 4'hA   // factory_restore_msg
   } lmc_msg_type;

   typedef enum logic [2:0] {
      DSP_ITEM    = 3'b000,
      DSP_LVL_CHG = 3'b001,
      DSP_LVL_SEL = 3'b010,
      DSP_BRIEF   = 3'b011,
      DSP_CONFIRM = 3'b100,
      DSP_FACTORY = 3'b101
   } lmc_dsp_type;
endpackage : lmc_pkg

/* hdl/lmc_hold_timer.sv */
`timescale 1ns/1ps
module lmc_hold_timer #(
   parameter int unsigned HOLD = 1
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic btn_i,
   output logic      long_o,
   output logic      short_o,
   output logic      done_o
);
   import lmc_pkg::*;

   logic [TMR_W-1:0] cnt_q;
   logic             seen_q;
   logic             btn_q;

   // hold counter, wraps each hold period for auto-repeat
   always_ff @(posedge clk_i) begin
      if (rst_i || !btn_i) begin
         cnt_q <= '0;
      end else if (long_o) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + TMR_W'(1);
      end
   end

   // remembers that this press has already acted
   always_ff @(posedge clk_i) begin
      if (rst_i || !btn_i) begin
         seen_q <= 1'b0;
      end else if (long_o) begin
         seen_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         btn_q <= 1'b0;
      end else begin
         btn_q <= btn_i;
      end
   end

   // long pulse at the end of each hold period; release pulses split by whether the press was long
   assign long_o  = btn_i && (cnt_q == TMR_W'(HOLD - 1));
   assign short_o = btn_q && !btn_i && !seen_q;
   assign done_o  = btn_q && !btn_i && seen_q;
endmodule : lmc_hold_timer

/* hdl/lmc_pct_div.sv */
`timescale 1ns/1ps
module lmc_pct_div (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        start_i,
   input  wire logic [31:0] num_i,
   input  wire logic [19:0] den_i,
   output logic             busy_o,
   output logic [19:0]      quo_o
);
   import lmc_pkg::*;

   logic [19:0] rem_q;
   logic [31:0] quo_q;
   logic [4:0]  cnt_q;
   logic        done_q;
   logic [20:0] trial;

   assign trial = {rem_q, quo_q[31]};

   // restoring division, one quotient bit per cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_o <= 1'b0;
         done_q <= 1'b0;
         cnt_q  <= '0;
         rem_q  <= '0;
         quo_q  <= '0;
      end else if (start_i && !busy_o) begin
         busy_o <= 1'b1;
         done_q <= 1'b0;
         cnt_q  <= '0;
         rem_q  <= '0;
         quo_q  <= num_i;
      end else if (busy_o) begin
         if (trial >= {1'b0, den_i}) begin
            rem_q <= 20'(trial - {1'b0, den_i});
            quo_q <= {quo_q[30:0], 1'b1};
         end else begin
            rem_q <= trial[19:0];
            quo_q <= {quo_q[30:0], 1'b0};
         end
         cnt_q  <= cnt_q + 5'h01;
         busy_o <= (cnt_q != 5'(DIV_CYC - 1));
         done_q <= (cnt_q == 5'(DIV_CYC - 1));
      end else begin
         done_q <= 1'b0;
      end
   end

   // result register, saturated to the display width
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         quo_o <= '0;
      end else if (done_q) begin
         quo_o <= (|quo_q[31:20]) ? VAL_MAX : quo_q[19:0];
      end
   end
endmodule : lmc_pct_div

/* hdl/lmc_top.sv */
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module lmc_top #(
   parameter int unsigned HOLD_CYCLES = lmc_pkg::HOLD_CYC,
   parameter int unsigned MSG_CYCLES  = lmc_pkg::MSG_CYC
) (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic [3:0]          rot_i,
   input  wire logic                plus_i,
   input  wire logic                minus_i,
   input  wire logic [19:0]         meas_i,
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [7:0]          wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [31:0]         wb_dat_i,
   output logic [31:0]              wb_dat_o,
   output logic                     wb_ack_o,
   output logic                     arrow_o,
   output lmc_pkg::lmc_msg_type     disp_msg_o,
   output logic [19:0]              disp_val_o
);
   import lmc_pkg::*;

   logic              level_q;
   logic              pct_mode_q;
   logic [1:0]        lock_q;
   logic [2:0]        step_exp_q;
   logic [19:0]       lrp_q;
   logic [19:0]       urp_q;
   lmc_dsp_type       dsp_q;
   logic [TMR_W-1:0]  msg_cnt_q;
   logic              ack_q;
   logic [31:0]       rd_q;

   logic              p_long, p_short, p_done;
   logic              m_long, m_short, m_done;
   logic              b_long, b_done;
   logic [4:0]        item;
   logic              at_zero;
   logic              unlocked;
   logic              msg_end;
   logic              bus_wr;
   logic [19:0]       step_val;
   logic [20:0]       urp_up;
   logic [20:0]       urp_dn;
   logic [19:0]       pct_val;
   logic              div_busy;
   logic [31:0]       div_num;
   logic [19:0]       span;

   assign item     = {level_q, rot_i};
   assign at_zero  = (rot_i == 4'h0);
   assign unlocked = (lock_q == 2'h0);
   assign msg_end  = (msg_cnt_q == '0);
   assign bus_wr   = ack_q && wb_we_i;

   // button hold timers, one per combination of buttons
   lmc_hold_timer #(.HOLD(HOLD_CYCLES)) u_plus (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .btn_i   (plus_i && !minus_i),
      .long_o  (p_long),
      .short_o (p_short),
      .done_o  (p_done)
   );

   lmc_hold_timer #(.HOLD(HOLD_CYCLES)) u_minus (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .btn_i   (minus_i && !plus_i),
      .long_o  (m_long),
      .short_o (m_short),
      .done_o  (m_done)
   );

   lmc_hold_timer #(.HOLD(HOLD_CYCLES)) u_both (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .btn_i   (plus_i && minus_i),
      .long_o  (b_long),
      .short_o (),
      .done_o  (b_done)
   );

   // step size value from decade exponent
   always_comb begin
      case (step_exp_q)
         3'h0:    step_val = 20'h00001;
         3'h1:    step_val = 20'h0000A;
         3'h2:    step_val = 20'h00064;
         3'h3:    step_val = 20'h003E8;
         3'h4:    step_val = 20'h02710;
         default: step_val = 20'h186A0;
      endcase
   end

   assign urp_up = {1'b0, urp_q} + {1'b0, step_val};
   assign urp_dn = {1'b0, urp_q} - {1'b0, step_val};

   // percent reading of the measured capacitance
   assign span    = urp_q - lrp_q;
   assign div_num = (meas_i > lrp_q) ? 32'(meas_i - lrp_q) * PCT_SCALE : 32'h0;

   lmc_pct_div u_div (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (!div_busy),
      .num_i   (div_num),
      .den_i   (span),
      .busy_o  (div_busy),
      .quo_o   (pct_val)
   );

   // menu level
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_q <= 1'b0;
      end else if (at_zero && m_long) begin
         level_q <= 1'b1;
      end else if (at_zero && p_long) begin
         level_q <= 1'b0;
      end
   end

   assign arrow_o = level_q;

   // keylock level, from the buttons at item 1F or from the bus
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_q <= LOCK_RST;
      end else if (bus_wr && wb_adr_i == REG_LOCK && wb_sel_i[0]) begin
         lock_q <= wb_dat_i[1:0];
      end else if (item == ITEM_LOCK && m_long && lock_q != 2'h0) begin
         lock_q <= lock_q - 2'h1;
      end else if (item == ITEM_LOCK && p_long && lock_q != LOCK_MAX) begin
         lock_q <= lock_q + 2'h1;
      end
   end

   // primary value representation
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pct_mode_q <= 1'b0;
      end else if (unlocked) begin
         if (item == ITEM_FAC && b_done) begin
            pct_mode_q <= 1'b0;
         end else if (item == ITEM_REP && (m_long || p_long)) begin
            pct_mode_q <= 1'b0;
         end else if (item == ITEM_REP && b_long) begin
            pct_mode_q <= 1'b1;
         end
      end
   end

   // step size in decades
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         step_exp_q <= STEP_RST;
      end else if (unlocked) begin
         if (item == ITEM_FAC && b_done) begin
            step_exp_q <= STEP_RST;
         end else if (item == ITEM_STEP && m_long && step_exp_q != 3'h0) begin
            step_exp_q <= step_exp_q - 3'h1;
         end else if (item == ITEM_STEP && p_long && step_exp_q != STEP_MAX) begin
            step_exp_q <= step_exp_q + 3'h1;
         end
      end
   end

   // lower range point, taken in pF representation only, without a calibration mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lrp_q <= LRP_RST;
      end else if (unlocked) begin
         if (item == ITEM_FAC && b_done) begin
            lrp_q <= LRP_RST;
         end else if (item == ITEM_LRP && !pct_mode_q && b_long) begin
            if ({1'b0, meas_i} + {1'b0, MIN_SPAN} <= {1'b0, urp_q}) begin
               lrp_q <= meas_i;
            end
         end
      end
   end

   // upper range point: capture in pF, step or snap in percent
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         urp_q <= URP_RST;
      end else if (unlocked && item == ITEM_FAC && b_done) begin
         urp_q <= URP_RST;
      end else if (unlocked && item == ITEM_URP) begin
         if (b_long && meas_i >= lrp_q + MIN_SPAN) begin
            urp_q <= meas_i;
         end else if (pct_mode_q && p_long && !urp_up[20]
                      && urp_up[19:0] >= lrp_q + MIN_SPAN) begin
            urp_q <= urp_up[19:0];
         end else if (pct_mode_q && m_long && !urp_dn[20]
                      && urp_dn[19:0] >= lrp_q + MIN_SPAN) begin
            urp_q <= urp_dn[19:0];
         end
      end
   end

   // display sequencing for messages
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dsp_q <= DSP_ITEM;
      end else begin
         case (dsp_q)
            DSP_ITEM: begin
               if (at_zero && (m_long || p_long)) begin
                  dsp_q <= DSP_LVL_CHG;
               end else if (at_zero && (m_short || p_short)) begin
                  dsp_q <= DSP_BRIEF;
               end else if (item == ITEM_FAC && b_long && unlocked) begin
                  dsp_q <= DSP_CONFIRM;
               end
            end
            DSP_LVL_CHG: begin
               if (m_done || p_done || (!plus_i && !minus_i)) begin
                  dsp_q <= DSP_ITEM;
               end else if (msg_end) begin
                  dsp_q <= DSP_LVL_SEL;
               end
            end
            DSP_LVL_SEL: begin
               if (!plus_i && !minus_i) begin
                  dsp_q <= DSP_ITEM;
               end
            end
            DSP_BRIEF: begin
               if (msg_end) begin
                  dsp_q <= DSP_ITEM;
               end
            end
            DSP_CONFIRM: begin
               if (b_done) begin
                  dsp_q <= DSP_FACTORY;
               end else if (!plus_i || !minus_i) begin
                  dsp_q <= DSP_ITEM;
               end
            end
            DSP_FACTORY: begin
               if (msg_end) begin
                  dsp_q <= DSP_ITEM;
               end
            end
            default: dsp_q <= DSP_ITEM;
         endcase
      end
   end

   // message timer, reloaded when a timed message starts
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         msg_cnt_q <= '0;
      end else if ((dsp_q == DSP_ITEM && at_zero && (m_long || p_long || m_short || p_short))
                   || (dsp_q == DSP_CONFIRM && b_done)) begin
         msg_cnt_q <= TMR_W'(MSG_CYCLES - 1);
      end else if (!msg_end) begin
         msg_cnt_q <= msg_cnt_q - TMR_W'(1);
      end
   end

   // display message and value registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         disp_msg_o <= MSG_PRIM;
         disp_val_o <= '0;
      end else begin
         case (dsp_q)
            DSP_LVL_CHG: begin
               disp_msg_o <= MSG_LVL_CHG;
               disp_val_o <= level_q ? 20'h00010 : 20'h00000;
            end
            DSP_LVL_SEL, DSP_BRIEF: begin
               disp_msg_o <= MSG_LVL_SEL;
               disp_val_o <= {19'h0, level_q};
            end
            DSP_CONFIRM: begin
               disp_msg_o <= MSG_CONFIRM;
               disp_val_o <= '0;
            end
            DSP_FACTORY: begin
               disp_msg_o <= MSG_FACTORY;
               disp_val_o <= '0;
            end
            default: begin
               case (item)
                  ITEM_REP: begin
                     disp_msg_o <= MSG_REP;
                     disp_val_o <= {19'h0, pct_mode_q};
                  end
                  ITEM_STEP: begin
                     disp_msg_o <= MSG_STEP;
                     disp_val_o <= step_val;
                  end
                  ITEM_LRP: begin
                     disp_msg_o <= MSG_LRP;
                     disp_val_o <= lrp_q;
                  end
                  ITEM_URP: begin
                     disp_msg_o <= pct_mode_q ? MSG_PCT : MSG_URP;
                     disp_val_o <= pct_mode_q ? pct_val : urp_q;
                  end
                  ITEM_LOCK: begin
                     disp_msg_o <= MSG_LOCK;
                     disp_val_o <= {18'h0, lock_q};
                  end
                  default: begin
                     disp_msg_o <= pct_mode_q ? MSG_PCT : MSG_PRIM;
                     disp_val_o <= pct_mode_q ? pct_val : meas_i;
                  end
               endcase
            end
         endcase
      end
   end

   // wishbone slave: ack one cycle after request, dropped the next
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      end
   end

   // read data captured with the ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_q <= '0;
      end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
         case (wb_adr_i)
            REG_STATUS: rd_q <= {21'h0, dsp_q, 2'h0, lock_q, 2'h0, pct_mode_q, level_q};
            REG_LRP:    rd_q <= {12'h0, lrp_q};
            REG_URP:    rd_q <= {12'h0, urp_q};
            REG_STEP:   rd_q <= {12'h0, step_val};
            REG_LOCK:   rd_q <= {30'h0, lock_q};
            REG_PCT:    rd_q <= {12'h0, pct_val};
            REG_DISP:   rd_q <= {8'h0, disp_msg_o, disp_val_o};
            default:    rd_q <= 32'h0;
         endcase
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rd_q;
endmodule : lmc_top

/* verif/lmc_operator.sv */
`timescale 1ns/1ps
module lmc_operator (
   input  wire logic       clk_i,
   output logic [3:0]      rot_o,
   output logic            plus_o,
   output logic            minus_o
);
   // switch parked at 0, buttons released
   initial begin
      rot_o = 4'h0;
      plus_o = 1'h0;
      minus_o = 1'h0;
   end

   // set switch, hold buttons n edges, release and settle
   task automatic press(input logic [3:0] r, input logic p, input logic m, input int n);
      @(posedge clk_i);
      rot_o <= r;
      repeat (2) @(posedge clk_i);
      plus_o <= p;
      minus_o <= m;
      repeat (n) @(posedge clk_i);
      plus_o <= 1'h0;
      minus_o <= 1'h0;
      repeat (4) @(posedge clk_i);
   endtask : press
endmodule : lmc_operator

/* verif/lmc_top_assertions.sv */
`timescale 1ns/1ps
module lmc_top_checker (
   input wire logic                 clk_i,
   input wire logic                 rst_i,
   input wire logic [3:0]           rot_i,
   input wire logic                 plus_i,
   input wire logic                 minus_i,
   input wire logic                 wb_cyc_i,
   input wire logic                 wb_stb_i,
   input wire logic                 wb_ack_o,
   input wire logic                 arrow_o,
   input wire lmc_pkg::lmc_msg_type disp_msg_o,
   input wire logic [19:0]          disp_val_o
);
   import lmc_pkg::*;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // level change messages: change code, then select code
   sequence s_msg_up;
      ##[0:2] (disp_msg_o == MSG_LVL_CHG && disp_val_o == 20'h00010)
      ##[1:12] (disp_msg_o == MSG_LVL_SEL && disp_val_o == 20'h00001);
   endsequence
   sequence s_msg_dn;
      ##[0:2] (disp_msg_o == MSG_LVL_CHG && disp_val_o == 20'h00000)
      ##[1:12] (disp_msg_o == MSG_LVL_SEL && disp_val_o == 20'h00000);
   endsequence

   property p_rst;
      $fell(rst_i) |-> !arrow_o && !wb_ack_o;
   endproperty
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   property p_ack_answer;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   property p_no_ack;
      !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
   endproperty
   property p_rot0;
      $changed(arrow_o) |-> $past(rot_i) == 4'h0;
   endproperty
   property p_up_btn;
      $rose(arrow_o) |-> $past(minus_i) && !$past(plus_i);
   endproperty
   property p_dn_btn;
      $fell(arrow_o) |-> $past(plus_i) && !$past(minus_i);
   endproperty
   property p_up_msg;
      $rose(arrow_o) |-> s_msg_up;
   endproperty
   property p_dn_msg;
      $fell(arrow_o) |-> s_msg_dn;
   endproperty

   a_rst: assert property (p_rst) else $error("arrow or ack after reset");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   a_ack_answer: assert property (p_ack_answer) else $error("request not acked");
   a_no_ack: assert property (p_no_ack) else $error("ack without request");
   a_rot0: assert property (p_rot0) else $error("level changed off position 0");
   a_up_btn: assert property (p_up_btn) else $error("upper level without minus");
   a_dn_btn: assert property (p_dn_btn) else $error("lower level without plus");
   a_up_msg: assert property (p_up_msg) else $error("wrong upper level messages");
   a_dn_msg: assert property (p_dn_msg) else $error("wrong lower level messages");
endmodule : lmc_top_checker

bind lmc_top lmc_top_checker i_lmc_top_checker (.clk_i(clk_i), .rst_i(rst_i),
   .rot_i(rot_i), .plus_i(plus_i), .minus_i(minus_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .arrow_o(arrow_o),
   .disp_msg_o(disp_msg_o), .disp_val_o(disp_val_o));

/* verif/lmc_top_bench.sv */
`timescale 1ns/1ps
module lmc_top_bench;
   import lmc_pkg::*;
   // bus, sensor and observed signals
   logic        clk_i = 1'h0;
   logic        rst_i = 1'h1;
   logic        cyc = 1'h0;
   logic        stb = 1'h0;
   logic        we = 1'h0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [19:0] meas = 20'h00000;
   logic [19:0] m0;
   logic [31:0] rnd;
   logic [31:0] rdat;
   logic        ack;
   logic        arrow;
   logic [3:0]  rot;
   logic        plus;
   logic        minus;
   logic [31:0] expq[$];
   int          seed = 79737;
   int          n_errors = 0;
   int          n_compared = 0;

   // 40 MHz clock
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   lmc_top #(.HOLD_CYCLES(8), .MSG_CYCLES(6)) i_lmc_top (.clk_i(clk_i), .rst_i(rst_i),
      .rot_i(rot), .plus_i(plus), .minus_i(minus), .meas_i(meas), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .arrow_o(arrow), .disp_msg_o(), .disp_val_o());
   lmc_operator i_lmc_operator (.clk_i(clk_i), .rot_o(rot), .plus_o(plus), .minus_o(minus));

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask : chk

   // one classic cycle; a read notes its expected word
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      if (!w) expq.push_back(d);
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
      do @(posedge clk_i); while (ack !== 1'h1);
      {cyc, stb, we} <= 3'h0;
   endtask : bus

   task automatic tally_and_finish;
      if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish

   // read answers against the oldest note, taken at the ack edge
   always @(posedge clk_i) begin
      if (ack === 1'h1 && we === 1'h0) begin
         chk("wb_dat_o", expq.size() > 0 ? expq.pop_front() : ~rdat, rdat);
      end
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      tally_and_finish();
   end

   // scenarios
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'h0;
      rnd = $random(seed);
      m0 = {8'h01, rnd[11:0]};
      bus(REG_STATUS, 1'h0, 32'h0);
      bus(REG_URP, 1'h0, {12'h0, URP_RST});
      bus(REG_STEP, 1'h0, 32'h64);
      bus(8'h1C, 1'h1, 32'h5);
      bus(8'h1C, 1'h0, 32'h0);
      i_lmc_operator.press(4'h0, 1'h0, 1'h1, 15);
      chk("arrow_o", 32'h1, {31'h0, arrow});
      bus(REG_STATUS, 1'h0, 32'h1);
      bus(REG_DISP, 1'h0, 32'h0);
      i_lmc_operator.press(4'h0, 1'h1, 1'h0, 3);
      bus(REG_DISP, 1'h0, 32'h00800001);
      i_lmc_operator.press(4'h3, 1'h1, 1'h0, 10);
      bus(REG_STATUS, 1'h0, 32'h1);
      bus(REG_LOCK, 1'h1, 32'h1);
      i_lmc_operator.press(4'hF, 1'h0, 1'h1, 10);
      bus(REG_DISP, 1'h0, 32'h00600000);
      bus(REG_LOCK, 1'h1, 32'h2);
      i_lmc_operator.press(4'h0, 1'h1, 1'h0, 15);
      chk("arrow_o", 32'h0, {31'h0, arrow});
      i_lmc_operator.press(4'h9, 1'h0, 1'h1, 10);
      bus(REG_STEP, 1'h0, 32'h64);
      bus(REG_DISP, 1'h0, 32'h00300064);
      bus(REG_LOCK, 1'h1, 32'h0);
      i_lmc_operator.press(4'h9, 1'h0, 1'h1, 10);
      bus(REG_STEP, 1'h0, 32'h0A);
      meas <= m0;
      i_lmc_operator.press(4'hE, 1'h1, 1'h1, 10);
      bus(REG_LRP, 1'h0, {12'h0, m0});
      meas <= m0 + 20'h00149;
      i_lmc_operator.press(4'hF, 1'h1, 1'h1, 10);
      bus(REG_URP, 1'h0, {12'h0, URP_RST});
      meas <= m0 + 20'h0014A;
      i_lmc_operator.press(4'hF, 1'h1, 1'h1, 10);
      bus(REG_DISP, 1'h0, {12'h005, m0 + 20'h0014A});
      i_lmc_operator.press(4'h1, 1'h1, 1'h1, 10);
      bus(REG_STATUS, 1'h0, 32'h2);
      meas <= m0 + 20'h000A5;
      repeat (80) @(posedge clk_i);
      bus(REG_PCT, 1'h0, 32'h1388);
      i_lmc_operator.press(4'hF, 1'h1, 1'h0, 10);
      bus(REG_URP, 1'h0, {12'h0, m0 + 20'h00154});
      meas <= m0 + 20'h00190;
      i_lmc_operator.press(4'hF, 1'h1, 1'h1, 10);
      repeat (80) @(posedge clk_i);
      bus(REG_PCT, 1'h0, 32'h2710);
      i_lmc_operator.press(4'h1, 1'h0, 1'h1, 10);
      bus(REG_STATUS, 1'h0, 32'h0);
      i_lmc_operator.press(4'h0, 1'h0, 1'h1, 15);
      i_lmc_operator.press(4'h2, 1'h1, 1'h1, 10);
      bus(REG_URP, 1'h0, {12'h0, URP_RST});
      bus(REG_LRP, 1'h0, 32'h0);
      repeat (2) @(posedge clk_i);
      tally_and_finish();
   end
endmodule : lmc_top_bench
